// ---- hw/ecdma_top.sv ----
// eight-channel dma controller: ahb-lite register slave plus one bus master
// assumes a single 20 MHz system clock shared by the bus, the master port and
// the peripheral request lines; external trigger pins are asynchronous
//
// Contract
// - eight independent channels, zero to seven
// - fixed priority, channel zero highest
// - addresses confined to lowest/highest 256 MB
// - per channel trigger: software, peripheral, pin
// - data unit 8, 16 or 32 bits
// - block and repeat size 1 to 1024
// - normal: one unit per request, free-run option
// - repeat: reload start address after repeat size
// - block: whole block per request
// - block count 16-bit field, up to 65536
// - total up to 64 M units
// - extended repeat area wraps low address bits
// - transfer-end flag when programmed count completes
// - escape-end flag on repeat cycle or overflow
// - event-link pulse per unit or per block
// - module stop: no transfers while stopped; a unit or block already under way still completes
// - read-only monitor of channels four to seven
// - master port on system clock main bus
//
// Chosen here: the AHB-Lite register port and the address map.
`include "ecdma_regs.svh"
module ecdma_top
   import ecdma_pkg::*;
(
   // clock and reset
   input  wire logic         clk,
   input  wire logic         nrst,
   // register bus
   input  wire ecd_ahb_in_t  ahb_i,
   output      ecd_ahb_out_t ahb_o,
   // main bus master
   output      ecd_mst_out_t mst_o,
   input  wire ecd_mst_in_t  mst_i,
   // request sources
   input  wire logic [7:0]   periph_req,
   input  wire logic [7:0]   pin_trig,
   // events
   output      logic [7:0]   irq_end,
   output      logic [7:0]   irq_esc,
   output      logic [7:0]   elink,
   output      logic         stopped
);
   ecd_state_t  s_reg;
   ecd_state_t  s_next;
   logic [7:0]  trig;
   logic [7:0]  elig;
   logic [2:0]  pick;
   logic        start;
   logic        wr_done;
   logic [2:0]  c;
   logic [1:0]  wd;
   logic [31:0] inc;
   logic [32:0] ss;
   logic [32:0] sd;
   logic [10:0] effs;
   logic        last;
   logic [2:0]  bc;
   logic [31:0] rdv;
   logic [31:0] wv;
   logic [7:0]  swset;

   function automatic logic [32:0] ecd_step(logic [31:0] a, logic [31:0] i, logic [4:0] e);
      logic [4:0]  x;
      logic [31:0] m;
      logic [31:0] sum;
      x = (e > `ECD_MAX_EXT) ? `ECD_MAX_EXT : e;
      m = (x == 5'h00) ? 32'h0FFFFFFF : ((32'h1 << x) - 32'h1);
      sum = a + i;
      return {(x != 5'h00) && ((sum & m) == 32'h0), (a & ~m) | (sum & m)};
   endfunction

   function automatic logic [10:0] ecd_eff(logic [10:0] v);
      return (v == 11'h000 || v > `ECD_MAX_SIZE) ? `ECD_MAX_SIZE : v;
   endfunction

   always_comb begin
      s_next = s_reg;
      s_next.elink = 8'h00;
      swset = 8'h00;
      // pin triggers: three stages, a rise counts once stages two and three agree
      s_next.p1 = pin_trig;
      s_next.p2 = s_reg.p1;
      s_next.p3 = s_reg.p2;
      for (int i = 0; i < 8; i++) begin
         if (s_reg.p2[i] == s_reg.p3[i]) begin
            s_next.pf[i] = s_reg.p3[i];
         end
         case (s_reg.mode[i][`ECD_MD_TRIG])
            ECD_TRG_PER: trig[i] = periph_req[i];
            ECD_TRG_PIN: trig[i] = s_next.pf[i] & ~s_reg.pf[i];
            default:     trig[i] = 1'b0;
         endcase
      end
      elig = s_reg.en & s_reg.pend;
      pick = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (elig[i]) begin
            pick = 3'(i);
         end
      end
      start = (s_reg.st == ECD_IDLE) && !s_reg.stop && (|elig);
      wr_done = (s_reg.st == ECD_WR) && mst_i.ready;
      c = s_reg.ch;
      wd = (s_reg.mode[c][`ECD_MD_WID] == 2'h3) ? 2'h2 : s_reg.mode[c][`ECD_MD_WID];
      inc = 32'h1 << wd;
      ss = ecd_step(s_reg.cur_s[c], inc, s_reg.mode[c][`ECD_MD_SEXT]);
      sd = ecd_step(s_reg.cur_d[c], inc, s_reg.mode[c][`ECD_MD_DEXT]);
      effs = ecd_eff(s_reg.size[c]);
      last = (s_reg.rem[c] <= 11'h001);

      // register read, sampled in the address phase
      bc = ahb_i.haddr[7:5];
      rdv = `ECD_RST_WORD;
      if (ahb_i.haddr[11:8] == `ECD_CH_REGION) begin
         case (ahb_i.haddr[4:2])
            `ECD_IX_SRC:  rdv = s_reg.src[bc];
            `ECD_IX_DST:  rdv = s_reg.dst[bc];
            `ECD_IX_SIZE: rdv = {21'h0, s_reg.size[bc]};
            `ECD_IX_BLK:  rdv = {16'h0, s_reg.blk[bc]};
            `ECD_IX_MODE: rdv = {11'h0, s_reg.mode[bc]};
            `ECD_IX_CTL:  rdv = {30'h0, s_reg.pend[bc], s_reg.en[bc]};
            `ECD_IX_STS:  rdv = {30'h0, s_reg.esc[bc], s_reg.te[bc]};
            default:      rdv = `ECD_RST_WORD;
         endcase
      end else if (ahb_i.haddr[11:0] == `ECD_OFS_GLB) begin
         rdv = {31'h0, s_reg.stop};
      end else if (ahb_i.haddr[11:0] == `ECD_OFS_MON) begin
         rdv = {28'h0, s_reg.te[7:4] | s_reg.esc[7:4]};
      end
      if (ahb_i.hsel && ahb_i.htrans[1] && ahb_i.hready) begin
         if (ahb_i.hwrite) begin
            s_next.wr_pend = 1'b1;
            s_next.waddr = ahb_i.haddr[11:0];
         end else begin
            s_next.hrdata = rdv;
         end
      end

      // register write in the data phase, during its one wait state
      bc = s_reg.waddr[7:5];
      wv = ahb_i.hwdata;
      if (s_reg.wr_pend) begin
         s_next.wr_pend = 1'b0;
         if (s_reg.waddr[11:8] == `ECD_CH_REGION) begin
            case (s_reg.waddr[4:2])
               `ECD_IX_SRC:  s_next.src[bc] = {{4{wv[31]}}, wv[27:0]};
               `ECD_IX_DST:  s_next.dst[bc] = {{4{wv[31]}}, wv[27:0]};
               `ECD_IX_SIZE: s_next.size[bc] = wv[10:0];
               `ECD_IX_BLK:  s_next.blk[bc] = wv[15:0];
               `ECD_IX_MODE: s_next.mode[bc] = wv[20:0];
               `ECD_IX_CTL: begin
                  s_next.en[bc] = wv[`ECD_CTL_EN];
                  if (wv[`ECD_CTL_EN] && !s_reg.en[bc]) begin
                     s_next.cur_s[bc] = s_reg.src[bc];
                     s_next.cur_d[bc] = s_reg.dst[bc];
                     s_next.rem[bc] = ecd_eff(s_reg.size[bc]);
                     s_next.rblk[bc] = (s_reg.blk[bc] == 16'h0) ? `ECD_MAX_BLK
                                       : {1'b0, s_reg.blk[bc]};
                  end
                  if (wv[`ECD_CTL_SWREQ] && wv[`ECD_CTL_EN]
                      && s_reg.mode[bc][`ECD_MD_TRIG] == ECD_TRG_SW) begin
                     swset[bc] = 1'b1;
                  end
               end
               `ECD_IX_STS: begin
                  s_next.te[bc] = s_reg.te[bc] & ~wv[`ECD_STS_END];
                  s_next.esc[bc] = s_reg.esc[bc] & ~wv[`ECD_STS_ESC];
               end
               default: ;
            endcase
         end else if (s_reg.waddr == `ECD_OFS_GLB) begin
            s_next.stop = wv[`ECD_GLB_STOP];
         end
      end

      // transfer engine: read one unit, then write it
      case (s_reg.st)
         ECD_IDLE: begin
            if (start) begin
               s_next.ch = pick;
               s_next.pend[pick] = 1'b0;
               s_next.st = ECD_RD;
               s_next.mst.req = 1'b1;
               s_next.mst.write = 1'b0;
               s_next.mst.addr = s_reg.cur_s[pick];
               s_next.mst.size = (s_reg.mode[pick][`ECD_MD_WID] == 2'h3) ? 2'h2
                                 : s_reg.mode[pick][`ECD_MD_WID];
            end
         end
         ECD_RD: begin
            if (mst_i.ready) begin
               s_next.mst.write = 1'b1;
               s_next.mst.addr = s_reg.cur_d[c];
               s_next.mst.wdata = mst_i.rdata;
               s_next.st = ECD_WR;
            end
         end
         ECD_WR: begin
            if (mst_i.ready) begin
               s_next.mst.req = 1'b0;
               s_next.mst.write = 1'b0;
               s_next.st = ECD_IDLE;
               s_next.cur_s[c] = ss[31:0];
               s_next.cur_d[c] = sd[31:0];
               if (ss[32] || sd[32]) begin
                  s_next.esc[c] = 1'b1;
               end
               case (s_reg.mode[c][`ECD_MD_XFER])
                  ECD_REPEAT: begin
                     s_next.elink[c] = 1'b1;
                     s_next.rem[c] = last ? effs : s_reg.rem[c] - 11'h001;
                     if (last) begin
                        if (s_reg.mode[c][`ECD_MD_RDST]) begin
                           s_next.cur_d[c] = s_reg.dst[c];
                        end else begin
                           s_next.cur_s[c] = s_reg.src[c];
                        end
                        s_next.esc[c] = 1'b1;
                        s_next.rblk[c] = s_reg.rblk[c] - 17'h00001;
                        if (s_reg.rblk[c] <= 17'h00001) begin
                           s_next.te[c] = 1'b1;
                           s_next.en[c] = 1'b0;
                        end
                     end
                  end
                  ECD_BLOCK: begin
                     s_next.rem[c] = last ? effs : s_reg.rem[c] - 11'h001;
                     if (!last) begin
                        s_next.st = ECD_RD;
                        s_next.mst.req = 1'b1;
                        s_next.mst.write = 1'b0;
                        s_next.mst.addr = ss[31:0];
                     end else begin
                        s_next.elink[c] = 1'b1;
                        s_next.rblk[c] = s_reg.rblk[c] - 17'h00001;
                        if (s_reg.rblk[c] <= 17'h00001) begin
                           s_next.te[c] = 1'b1;
                           s_next.en[c] = 1'b0;
                        end
                     end
                  end
                  default: begin
                     s_next.elink[c] = 1'b1;
                     if (!s_reg.mode[c][`ECD_MD_FREE]) begin
                        s_next.rblk[c] = s_reg.rblk[c] - 17'h00001;
                        if (s_reg.rblk[c] <= 17'h00001) begin
                           s_next.te[c] = 1'b1;
                           s_next.en[c] = 1'b0;
                        end
                     end
                  end
               endcase
            end
         end
         default: begin
            s_next.st = ECD_IDLE;
            s_next.mst.req = 1'b0;
         end
      endcase

      // requests latch once; a new one wins over the clear at start
      for (int i = 0; i < 8; i++) begin
         if ((trig[i] || swset[i]) && s_next.en[i]) begin
            s_next.pend[i] = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_reg <= '0;
         s_reg.size <= {8{`ECD_RST_SIZE}};
         s_reg.stop <= `ECD_RST_STOP;
         s_reg.st <= ECD_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end

   assign ahb_o.hreadyout = !s_reg.wr_pend;
   assign ahb_o.hresp = 1'b0;
   assign ahb_o.hrdata = s_reg.hrdata;
   assign mst_o = s_reg.mst;
   assign irq_end = s_reg.te;
   assign irq_esc = s_reg.esc;
   assign elink = s_reg.elink;
   assign stopped = s_reg.stop;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   prio_pick_a: assert property (start |-> ((elig & ((8'h01 << pick) - 8'h01)) == 8'h00))
      else $error("lower-priority channel granted");
   stop_hold_a: assert property (s_reg.stop && s_reg.st == ECD_IDLE |=> s_reg.st == ECD_IDLE)
      else $error("transfer started while stopped");
   addr_space_a: assert property (mst_o.req |-> mst_o.addr[31:28] inside {4'h0, 4'hF})
      else $error("master address outside transfer space");
   unit_size_a: assert property (mst_o.req |-> mst_o.size <= 2'h2)
      else $error("illegal unit size");
   elink_src_a: assert property ((|s_reg.elink) |-> $past(wr_done))
      else $error("event link without completed write");
   block_cont_a: assert property (wr_done && s_reg.mode[c][`ECD_MD_XFER] == ECD_BLOCK
      && !last |=> s_reg.st == ECD_RD && s_reg.ch == $past(s_reg.ch) && mst_o.req
      && !mst_o.write)
      else $error("block transfer broke off early");
   normal_one_a: assert property (wr_done && s_reg.mode[c][`ECD_MD_XFER] == ECD_NORMAL
      |=> s_reg.st == ECD_IDLE && !mst_o.req)
      else $error("normal mode moved more than one unit");
   pend_latch_a: assert property (trig[0] && s_next.en[0] |=> s_reg.pend[0])
      else $error("request lost");
   rd_hold_a: assert property (mst_o.req && !mst_o.write && !mst_i.ready
      |=> mst_o.req && !mst_o.write && $stable(mst_o.addr))
      else $error("read phase not held until ready");
   wr_wait_a: assert property (s_reg.wr_pend |-> !ahb_o.hreadyout ##1 ahb_o.hreadyout)
      else $error("write wait state wrong");
   repeat_end_a: assert property (wr_done && s_reg.mode[c][`ECD_MD_XFER] == ECD_REPEAT
      && last |=> s_reg.esc[$past(c)])
      else $error("repeat cycle without escape flag");

   block_run_c: cover property (wr_done && s_reg.mode[c][`ECD_MD_XFER] == ECD_BLOCK ##1
      s_reg.st == ECD_RD);
   end_flag_c: cover property ($rose(s_reg.te[0]));
   esc_flag_c: cover property ($rose(s_reg.esc[1]));
   pin_start_c: cover property (trig[2] && s_reg.mode[2][`ECD_MD_TRIG] == ECD_TRG_PIN);
endmodule

// ---- hw/ecdma_regs.svh ----
// register offsets, field positions and reset values of the eight-channel dma
// assumes byte addresses on the register bus, one 32-bit word per register
`ifndef ECDMA_REGS_SVH
`define ECDMA_REGS_SVH
// channel n window starts at n * 32 bytes, word index in bits 4:2
`define ECD_CH_REGION  4'h0
`define ECD_IX_SRC     3'h0
`define ECD_IX_DST     3'h1
`define ECD_IX_SIZE    3'h2
`define ECD_IX_BLK     3'h3
`define ECD_IX_MODE    3'h4
`define ECD_IX_CTL     3'h5
`define ECD_IX_STS     3'h6
`define ECD_OFS_GLB    12'h100
`define ECD_OFS_MON    12'h104
// mode word fields
`define ECD_MD_XFER    1:0
`define ECD_MD_WID     3:2
`define ECD_MD_TRIG    5:4
`define ECD_MD_RDST    6
`define ECD_MD_FREE    7
`define ECD_MD_SEXT    12:8
`define ECD_MD_DEXT    20:16
`define ECD_CTL_EN     0
`define ECD_CTL_SWREQ  1
`define ECD_STS_END    0
`define ECD_STS_ESC    1
`define ECD_GLB_STOP   0
// reset values and limits
`define ECD_RST_WORD   32'h00000000
`define ECD_RST_SIZE   11'h001
`define ECD_RST_STOP   1'b0
`define ECD_MAX_SIZE   11'h400
`define ECD_MAX_BLK    17'h10000
`define ECD_MAX_EXT    5'h1B
`endif

// ---- hw/ecdma_pkg.sv ----
// types shared by the eight-channel dma: bus carriers, modes, engine states
// assumes nothing beyond a SystemVerilog compiler
package ecdma_pkg;
   typedef enum logic [1:0] {
      ECD_NORMAL = 2'h0,
      ECD_REPEAT = 2'h1,
      ECD_BLOCK  = 2'h2
   } ecd_xfer_t;
   typedef enum logic [1:0] {
      ECD_TRG_SW  = 2'h0,
      ECD_TRG_PER = 2'h1,
      ECD_TRG_PIN = 2'h2
   } ecd_trig_t;
   typedef enum logic [2:0] {
      ECD_IDLE = 3'b001,
      ECD_RD   = 3'b010,
      ECD_WR   = 3'b100
   } ecd_st_t;
   typedef struct packed {
      logic        hsel;
      logic [31:0] haddr;
      logic [1:0]  htrans;
      logic        hwrite;
      logic [2:0]  hsize;
      logic [31:0] hwdata;
      logic        hready;
   } ecd_ahb_in_t;
   typedef struct packed {
      logic        hreadyout;
      logic        hresp;
      logic [31:0] hrdata;
   } ecd_ahb_out_t;
   typedef struct packed {
      logic        req;
      logic        write;
      logic [1:0]  size;
      logic [31:0] addr;
      logic [31:0] wdata;
   } ecd_mst_out_t;
   typedef struct packed {
      logic        ready;
      logic [31:0] rdata;
   } ecd_mst_in_t;
   typedef struct packed {
      logic [7:0][31:0] src;
      logic [7:0][31:0] dst;
      logic [7:0][31:0] cur_s;
      logic [7:0][31:0] cur_d;
      logic [7:0][10:0] size;
      logic [7:0][10:0] rem;
      logic [7:0][15:0] blk;
      logic [7:0][16:0] rblk;
      logic [7:0][20:0] mode;
      logic [7:0]       en;
      logic [7:0]       pend;
      logic [7:0]       te;
      logic [7:0]       esc;
      logic [7:0]       elink;
      logic [7:0]       p1;
      logic [7:0]       p2;
      logic [7:0]       p3;
      logic [7:0]       pf;
      logic             stop;
      ecd_st_t          st;
      logic [2:0]       ch;
      logic             wr_pend;
      logic [11:0]      waddr;
      logic [31:0]      hrdata;
      ecd_mst_out_t     mst;
   } ecd_state_t;
endpackage

// ---- tb/ecdma_mem_model.sv ----
// memory model on the far side of the dma master port
// assumes the dma clock; read data is a pattern of the address, writes are logged
module ecdma_mem_model
   import ecdma_pkg::*;
(
   // clock and reset
   input  wire logic         clk,
   input  wire logic         nrst,
   // master port of the dma
   input  wire ecd_mst_out_t mst_o,
   output      ecd_mst_in_t  mst_i,
   // stall length and write log
   input  wire logic [3:0]   slow,
   output      logic [31:0]  wr_cnt,
   output      logic [31:0]  wr_addr,
   output      logic [31:0]  wr_data
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0]  wait_cnt;
   logic [31:0] last_rd;
   // outside a read phase the data lines carry garbage, not the last word
   always_comb begin
      mst_i.ready = mst_o.req && (wait_cnt == slow);
      mst_i.rdata = (mst_i.ready && !mst_o.write) ? (mst_o.addr ^ 32'h5A5A0000) : ~last_rd;
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wait_cnt <= 4'h0;
         last_rd  <= 32'h00000000;
         wr_cnt   <= 32'h00000000;
         wr_addr  <= 32'h00000000;
         wr_data  <= 32'h00000000;
      end else begin
         wait_cnt <= (mst_o.req && !mst_i.ready) ? wait_cnt + 4'h1 : 4'h0;
         if (mst_i.ready && !mst_o.write) begin
            last_rd <= mst_i.rdata;
         end
         if (mst_i.ready && mst_o.write) begin
            wr_cnt  <= wr_cnt + 32'h00000001;
            wr_addr <= mst_o.addr;
            wr_data <= mst_o.wdata;
         end
      end
   end
endmodule

// ---- tb/tb_eight_channel_dma_controller.sv ----
// self-checking bench of the eight-channel dma: ahb-lite tasks and transfer scenarios
// assumes ecdma_top and the memory model on its master port
module tb_eight_channel_dma_controller;
   import ecdma_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic         clk;
   logic         nrst;
   ecd_ahb_in_t  bus;
   ecd_ahb_in_t  ahb_in;
   ecd_ahb_out_t ahb_o;
   ecd_mst_out_t mst_o;
   ecd_mst_in_t  mst_i;
   logic [7:0]   periph_req;
   logic [7:0]   pin_trig;
   logic [7:0]   irq_end;
   logic [7:0]   irq_esc;
   logic [7:0]   elink;
   logic         stopped;
   logic [3:0]   slow;
   logic [31:0]  wr_cnt;
   logic [31:0]  wr_addr;
   logic [31:0]  wr_data;
   logic [31:0]  rdv;
   logic [31:0]  c0;
   int           error_cnt;
   int           check_count;

   ecdma_top u_ecdma_top (.clk(clk), .nrst(nrst), .ahb_i(ahb_in), .ahb_o(ahb_o),
      .mst_o(mst_o), .mst_i(mst_i), .periph_req(periph_req), .pin_trig(pin_trig),
      .irq_end(irq_end), .irq_esc(irq_esc), .elink(elink), .stopped(stopped));
   ecdma_mem_model u_ecdma_mem_model (.clk(clk), .nrst(nrst), .mst_o(mst_o), .mst_i(mst_i),
      .slow(slow), .wr_cnt(wr_cnt), .wr_addr(wr_addr), .wr_data(wr_data));

   // the single slave's hreadyout is the bus ready
   always_comb begin
      ahb_in        = bus;
      ahb_in.hready = ahb_o.hreadyout;
   end

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   function automatic logic [31:0] pat(input logic [31:0] a);
      return a ^ 32'h5A5A0000;
   endfunction

   task automatic give_verdict;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus.hsel   <= 1'b1;
      bus.haddr  <= {20'h00000, a};
      bus.htrans <= 2'h2;
      bus.hwrite <= 1'b1;
      bus.hsize  <= 3'h2;
      do @(posedge clk); while (ahb_o.hreadyout !== 1'b1);
      bus.hsel   <= 1'b0;
      bus.htrans <= 2'h0;
      bus.hwdata <= d;
      do @(posedge clk); while (ahb_o.hreadyout !== 1'b1);
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      bus.hsel   <= 1'b1;
      bus.haddr  <= {20'h00000, a};
      bus.htrans <= 2'h2;
      bus.hwrite <= 1'b0;
      bus.hsize  <= 3'h2;
      do @(posedge clk); while (ahb_o.hreadyout !== 1'b1);
      bus.hsel   <= 1'b0;
      bus.htrans <= 2'h0;
      do @(posedge clk); while (ahb_o.hreadyout !== 1'b1);
      d = ahb_o.hrdata;
   endtask

   task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
      rd(a, rdv);
      chk(what, exp, rdv);
   endtask

   // settings go in while the channel is off, then enable loads them
   task automatic cfg(input logic [2:0] ch, input logic [31:0] s, input logic [31:0] d,
                      input logic [31:0] sz, input logic [31:0] bk, input logic [31:0] md);
      wr({4'h0, ch, 5'h14}, 32'h00000000);
      wr({4'h0, ch, 5'h00}, s);
      wr({4'h0, ch, 5'h04}, d);
      wr({4'h0, ch, 5'h08}, sz);
      wr({4'h0, ch, 5'h0C}, bk);
      wr({4'h0, ch, 5'h10}, md);
      wr({4'h0, ch, 5'h14}, 32'h00000001);
   endtask

   task automatic req(input logic [2:0] ch);
      wr({4'h0, ch, 5'h14}, 32'h00000003);
   endtask

   task automatic wait_el(input logic [2:0] ch);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (elink[ch] !== 1'b1 && n < 300);
      chk("elink", 32'h00000001, {31'h00000000, elink[ch]});
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      give_verdict();
   end

   initial begin
      nrst = 1'b0;
      bus = '0;
      periph_req = 8'h00;
      pin_trig = 8'h00;
      slow = 4'h0;
      error_cnt = 0;
      check_count = 0;
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      chk("hreadyout", 32'h1, {31'h0, ahb_o.hreadyout});
      chk("flags", 32'h0, {16'h0, irq_end, irq_esc});
      chk("stopped", 32'h0, {31'h0, stopped});
      chk("hresp", 32'h0, {31'h0, ahb_o.hresp});
      // registers: address space folding, unmapped, read-only, reset size
      rchk("size reset", 12'h0A8, 32'h00000001);
      wr(12'h000, 32'h80000100);
      rchk("src fold", 12'h000, 32'hF0000100);
      rchk("unmapped", 12'h200, 32'h00000000);
      wr(12'h104, 32'h0000000F);
      rchk("monitor", 12'h104, 32'h00000000);
      // normal mode, software trigger, count of two
      cfg(3'h0, 32'h00000100, 32'h00002000, 32'h1, 32'h2, 32'h08);
      req(3'h0);
      wait_el(3'h0);
      chk("dst", 32'h00002000, wr_addr);
      chk("data", pat(32'h00000100), wr_data);
      chk("end early", 32'h0, {31'h0, irq_end[0]});
      req(3'h0);
      wait_el(3'h0);
      chk("dst 2", 32'h00002004, wr_addr);
      chk("end", 32'h1, {31'h0, irq_end[0]});
      rchk("status", 12'h018, 32'h00000001);
      wr(12'h018, 32'h00000001);
      rchk("status clr", 12'h018, 32'h00000000);
      // simultaneous peripheral requests on channels zero and one
      cfg(3'h0, 32'h00000200, 32'h00004000, 32'h1, 32'h4, 32'h18);
      cfg(3'h1, 32'h00000300, 32'h00003000, 32'h1, 32'h4, 32'h18);
      c0 = wr_cnt;
      periph_req <= 8'h03;
      @(posedge clk);
      periph_req <= 8'h00;
      wait_el(3'h0);
      chk("first served", c0 + 32'h1, wr_cnt);
      chk("first dst", 32'h00004000, wr_addr);
      wait_el(3'h1);
      chk("second dst", 32'h00003000, wr_addr);
      // a request held during a transfer counts once more
      c0 = wr_cnt;
      periph_req <= 8'h02;
      repeat (3) @(posedge clk);
      periph_req <= 8'h00;
      repeat (30) @(posedge clk);
      chk("held req", c0 + 32'h2, wr_cnt);
      // block of three with a stalling memory
      slow <= 4'h3;
      cfg(3'h2, 32'h00000500, 32'h00006000, 32'h3, 32'h1, 32'h0A);
      c0 = wr_cnt;
      req(3'h2);
      wait_el(3'h2);
      chk("block units", c0 + 32'h3, wr_cnt);
      chk("block last", pat(32'h00000508), wr_data);
      chk("block end", 32'h1, {31'h0, irq_end[2]});
      slow <= 4'h0;
      // repeat of two units on the source side
      cfg(3'h3, 32'h00000700, 32'h00007000, 32'h2, 32'h2, 32'h09);
      req(3'h3);
      wait_el(3'h3);
      chk("esc early", 32'h0, {31'h0, irq_esc[3]});
      req(3'h3);
      wait_el(3'h3);
      chk("esc", 32'h1, {31'h0, irq_esc[3]});
      req(3'h3);
      wait_el(3'h3);
      chk("reload", pat(32'h00000700), wr_data);
      chk("dst runs", 32'h00007008, wr_addr);
      // four-byte source area, pin trigger
      cfg(3'h5, 32'h00000840, 32'h00009000, 32'h1, 32'h0, 32'h228);
      pin_trig[5] <= 1'b1;
      wait_el(3'h5);
      pin_trig[5] <= 1'b0;
      chk("area esc", 32'h1, {31'h0, irq_esc[5]});
      repeat (8) @(posedge clk);
      pin_trig[5] <= 1'b1;
      wait_el(3'h5);
      pin_trig[5] <= 1'b0;
      chk("area wrap", pat(32'h00000840), wr_data);
      rchk("monitor 5", 12'h104, 32'h00000002);
      // free-running byte transfers never end on count
      cfg(3'h6, 32'h00000900, 32'h0000A000, 32'h1, 32'h1, 32'h80);
      req(3'h6);
      wait_el(3'h6);
      req(3'h6);
      wait_el(3'h6);
      chk("byte dst", 32'h0000A001, wr_addr);
      chk("byte data", pat(32'h00000901), wr_data);
      chk("free no end", 32'h0, {31'h0, irq_end[6]});
      // module stop holds off a pending request
      cfg(3'h0, 32'h00000A00, 32'h0000B000, 32'h1, 32'h0, 32'h08);
      wr(12'h100, 32'h00000001);
      chk("stopped", 32'h1, {31'h0, stopped});
      c0 = wr_cnt;
      req(3'h0);
      repeat (20) @(posedge clk);
      chk("no xfer", c0, wr_cnt);
      wr(12'h100, 32'h00000000);
      wait_el(3'h0);
      chk("resume", 32'h0000B000, wr_addr);
      give_verdict();
   end
endmodule
